// ==== bus_data_prom_reader_test.sv ====
// testbench: two sequencer and attachment pairs, the second without a high prom.
// assumes the design files and the package are compiled first.
`timescale 1ns/10ps
module bus_data_prom_reader_test;
    import prom_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    op_e cmd_op = OP_SET_A;
    logic [WORD_W-1:0] cmd_data = 16'h0000;
    logic tape_valid = 1'b0;
    logic [7:0] tape_char = 8'h00;
    logic tape_sel = 1'b0;
    logic cmd_ready, cmd_done, cmd_error, tape_end, read_active;
    logic [WORD_W-1:0] reg_a, reg_b, reg_a2, reg_b2;
    logic [ADDR_W-1:0] prom_address_latch;
    int n_fail = 0;
    int total_checks = 0;
    int n;
    rt_bus_if bus();
    rt_bus_if bus2();
    always #2 clk_sys = ~clk_sys;
    prom_attachment prom_attachment_inst (.clk_sys(clk_sys), .reset(reset),
        .bus(bus.attachment), .prom_address_latch(prom_address_latch),
        .read_active(read_active));
    prom_attachment #(.HIGH_FITTED(1'b0)) prom_attachment_inst2 (.clk_sys(clk_sys),
        .reset(reset), .bus(bus2.attachment), .prom_address_latch(), .read_active());
    prom_sequencer prom_sequencer_inst (.clk_sys(clk_sys), .reset(reset),
        .bus(bus.sequencer), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_error(cmd_error), .reg_a(reg_a),
        .reg_b(reg_b), .tape_valid(tape_valid), .tape_char(tape_char),
        .tape_sel(tape_sel), .tape_end(tape_end));
    // the second pair shares all stimulus, so its timing matches the first
    prom_sequencer prom_sequencer_inst2 (.clk_sys(clk_sys), .reset(reset),
        .bus(bus2.sequencer), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
        .cmd_ready(), .cmd_done(), .cmd_error(), .reg_a(reg_a2), .reg_b(reg_b2),
        .tape_valid(tape_valid), .tape_char(tape_char), .tape_sel(tape_sel), .tape_end());
    prom_attachment_chk prom_attachment_chk_inst (.clk_sys(clk_sys), .reset(reset),
        .evoke_code(bus.evoke_code), .evoke_strobe(bus.evoke_strobe),
        .dst_data(bus.dst_data), .dst_drive(bus.dst_drive), .evoke_done(bus.evoke_done),
        .prog_we(bus.prog_we), .prog_sel(bus.prog_sel));

    task automatic chk_w(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int exp);
        total_checks++;
        if (got != exp) begin
            n_fail++;
            $display("BAD at %0t: took %0d cycles, expected %0d", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // n counts edges from the taking edge to the one that raises cmd_done
    task automatic run_cmd(input op_e op, input logic [WORD_W-1:0] d, output int n);
        n = 0;
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_data <= d;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        // a one-cycle answer stands right after the taking edge, so look there first
        #1;
        while (cmd_done !== 1'b1 && n < 1000) begin
            @(posedge clk_sys);
            n++;
            #1;
        end
        if (cmd_done !== 1'b1) begin
            n_fail++;
            $display("BAD at %0t: command never finished", $time);
        end
    endtask
    task automatic tape(input string s, input logic sel);
        foreach (s[i]) begin
            @(posedge clk_sys);
            tape_valid <= 1'b1;
            tape_char <= s[i];
            tape_sel <= sel;
        end
        @(posedge clk_sys);
        tape_valid <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    initial begin
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        run_cmd(OP_READ_A, 16'h0000, n);
        chk_n(n, 0);
        chk_w({15'h0000, cmd_error}, 16'h0001);
        chk_w(reg_a, 16'h0000);
        $display("test refused_read done");
        // the four-digit entry must be dropped, leaving location 000 intact
        tape("101\015\012%0001234\015\012%005252\015\012", 1'b0);
        tape("%000303\015\012%005017\015\012$", 1'b1);
        chk_w({15'h0000, tape_end}, 16'h0001);
        $display("test tape_load done");
        run_cmd(OP_SET_A, 16'hab05, n);
        run_cmd(OP_ADDR_A, 16'h0000, n);
        chk_n(n, ADDR_CYC + 2);
        chk_w({8'h00, prom_address_latch}, 16'h0005);
        run_cmd(OP_READ_B, 16'h0000, n);
        chk_n(n, READ_CYC + 2);
        chk_w(reg_b, 16'h0faa);
        chk_w(reg_b2, {ABSENT_BYTE, 8'haa});
        chk_w({14'h0000, cmd_ready, read_active}, 16'h0002);
        run_cmd(OP_READ_A, 16'h0000, n);
        chk_n(n, READ_CYC + 2);
        chk_w(reg_a, 16'h0faa);
        $display("test address_a_reads done");
        run_cmd(OP_SET_B, 16'h7f00, n);
        run_cmd(OP_ADDR_B, 16'h0000, n);
        chk_n(n, ADDR_CYC + 2);
        chk_w({8'h00, prom_address_latch}, 16'h0000);
        run_cmd(OP_READ_A, 16'h0000, n);
        chk_w(reg_a, 16'hc341);
        chk_w(reg_a2, {ABSENT_BYTE, 8'h41});
        run_cmd(OP_INVERT_A, 16'h0000, n);
        chk_n(n, INVERT_CYC);
        chk_w(reg_a, ~16'hc341);
        run_cmd(OP_INVERT_B, 16'h0000, n);
        chk_w(reg_b, ~16'h7f00);
        $display("test address_b_invert done");
        close_out();
    end

    // about ten commands of at most 600 cycles each; 20000 cycles is ample
    initial begin
        #80000;
        n_fail++;
        $display("BAD at %0t: run did not finish", $time);
        close_out();
    end
endmodule

// ==== prom_attachment.sv ====
// data prom attachment: address latch, two byte proms and bus gating.
// assumes the sequencer strobes one evoke at a time and waits for evoke_done.
`timescale 1ns/10ps
module prom_attachment #(
    parameter bit LOW_FITTED = 1'b1,
    parameter bit HIGH_FITTED = 1'b1
) (
    input wire logic clk_sys, // system clock
    input wire logic reset, // synchronous reset, active high
    rt_bus_if.attachment bus, // register transfer bus
    output logic [prom_pkg::ADDR_W-1:0] prom_address_latch, // current latched address
    output logic read_active // high while a prom word is on the bus
);
    import prom_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_READ
    } state_e;

    state_e state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [WORD_W-1:0] out_q, out_d;
    logic drive_q, drive_d;
    logic done_q, done_d;
    logic [WORD_W-1:0] word;

    // low and high byte positions; both are read at the one latched address
    prom_byte_bank #(.DEPTH(DEPTH), .WIDTH(BYTE_W), .FITTED(LOW_FITTED)) u_low (
        .clk_sys(clk_sys),
        .reset(reset),
        .we(bus.prog_we && !bus.prog_sel),
        .waddr(bus.prog_addr),
        .wdata(bus.prog_data),
        .raddr(addr_q),
        .rdata(word[BYTE_W-1:0])
    );

    prom_byte_bank #(.DEPTH(DEPTH), .WIDTH(BYTE_W), .FITTED(HIGH_FITTED)) u_high (
        .clk_sys(clk_sys),
        .reset(reset),
        .we(bus.prog_we && bus.prog_sel),
        .waddr(bus.prog_addr),
        .wdata(bus.prog_data),
        .raddr(addr_q),
        .rdata(word[WORD_W-1:BYTE_W])
    );

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        out_d = out_q;
        drive_d = drive_q;
        done_d = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                if (bus.evoke_strobe) begin
                    if (bus.evoke_code == EVK_ADDR_FROM_A
                            || bus.evoke_code == EVK_ADDR_FROM_B) begin
                        // only the low byte addresses the 256 locations
                        addr_d = bus.src_data[ADDR_W-1:0];
                        cnt_d = CNT_W'(ADDR_CYC - 1);
                        state_d = ST_ADDR;
                    end else if (bus.evoke_code == EVK_READ_TO_A
                            || bus.evoke_code == EVK_READ_TO_B) begin
                        cnt_d = CNT_W'(READ_CYC - 1);
                        state_d = ST_READ;
                    end
                end
            end
            ST_ADDR: begin
                if (cnt_q == '0) begin
                    done_d = 1'b1;
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            ST_READ: begin
                // bank read data is valid from the first cycle of the read, the address having been latched before
                drive_d = 1'b1;
                out_d = word; // no inversion on the way out
                if (cnt_q == '0) begin
                    done_d = 1'b1;
                    drive_d = 1'b0;
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            addr_q <= '0; // held otherwise until the next address evoke
            out_q <= '1;
            drive_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            out_q <= out_d;
            drive_q <= drive_d;
            done_q <= done_d;
        end
    end

    assign bus.dst_data = out_q;
    assign bus.dst_drive = drive_q;
    assign bus.evoke_done = done_q;
    assign prom_address_latch = addr_q;
    assign read_active = drive_q;
endmodule

// ==== prom_attachment_chk.sv ====
// checker for the evoke and loader traffic on the register transfer bus.
// assumes one clk_sys domain; instantiated by the testbench beside the interface.
`timescale 1ns/10ps
module prom_attachment_chk (
    input wire logic clk_sys, // system clock
    input wire logic reset, // synchronous reset
    input wire logic [prom_pkg::CODE_W-1:0] evoke_code, // evoke code
    input wire logic evoke_strobe, // evoke start
    input wire logic [prom_pkg::WORD_W-1:0] dst_data, // prom word
    input wire logic dst_drive, // attachment drives bus
    input wire logic evoke_done, // evoke finished
    input wire logic prog_we, // loader write
    input wire logic prog_sel // loader target prom
);
    import prom_pkg::*;
    logic busy_q, busy_d, rd;
    logic [CNT_W-1:0] cyc_q, cyc_d;
    logic [CODE_W-1:0] code_q, code_d;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    assign rd = code_q == EVK_READ_TO_A || code_q == EVK_READ_TO_B;
    // cyc_q counts the edges since the one that took the strobe
    always_comb begin
        busy_d = busy_q;
        cyc_d = cyc_q;
        code_d = code_q;
        if (reset || evoke_done) begin
            busy_d = 1'b0;
        end else if (busy_q) begin
            cyc_d = cyc_q + 1'b1;
        end else if (evoke_strobe && evoke_code inside
                {EVK_ADDR_FROM_A, EVK_ADDR_FROM_B, EVK_READ_TO_A, EVK_READ_TO_B}) begin
            busy_d = 1'b1;
            cyc_d = '0;
            code_d = evoke_code;
        end
    end
    always_ff @(posedge clk_sys) begin
        busy_q <= busy_d;
        cyc_q <= cyc_d;
        code_q <= code_d;
    end
    a_addr_a_time: assert property (
        busy_q && code_q == EVK_ADDR_FROM_A && cyc_q == ADDR_CYC |-> evoke_done)
        else $error("address from a late");
    a_addr_b_time: assert property (
        busy_q && code_q == EVK_ADDR_FROM_B && cyc_q == ADDR_CYC |-> evoke_done)
        else $error("address from b late");
    a_read_a_time: assert property (
        busy_q && code_q == EVK_READ_TO_A && cyc_q == READ_CYC |-> evoke_done)
        else $error("read to a late");
    a_read_b_time: assert property (
        busy_q && code_q == EVK_READ_TO_B && cyc_q == READ_CYC |-> evoke_done)
        else $error("read to b late");
    a_done_in_window: assert property (
        evoke_done |-> busy_q && cyc_q == (rd ? READ_CYC : ADDR_CYC))
        else $error("done outside its cycle");
    a_drive_span: assert property (
        dst_drive == (busy_q && rd && cyc_q > 0 && cyc_q < READ_CYC))
        else $error("bus drive outside read");
    a_word_steady: assert property (
        busy_q && rd && cyc_q > 2 && cyc_q < READ_CYC |-> $stable(dst_data))
        else $error("read word moved");
    a_load_spacing: assert property (
        prog_we |=> (!prog_we) [*4])
        else $error("loader writes too close");
    a_one_at_a_time: assert property (
        evoke_strobe |-> !busy_q)
        else $error("strobe while busy");
    cover property (evoke_done && rd);
    cover property (evoke_done && !rd);
    cover property (prog_we && prog_sel);
endmodule

// ==== prom_byte_bank.sv ====
// one byte-wide prom position: 256 x 8 array, write port for loading, registered read.
// assumes the caller holds the address stable; an unfitted bank reads all ones.
`timescale 1ns/10ps
module prom_byte_bank #(
    parameter int DEPTH = prom_pkg::DEPTH,
    parameter int WIDTH = prom_pkg::BYTE_W,
    parameter bit FITTED = 1'b1
) (
    input wire logic clk_sys, // system clock
    input wire logic reset, // synchronous reset
    input wire logic we, // load strobe
    input wire logic [$clog2(DEPTH)-1:0] waddr, // load address
    input wire logic [WIDTH-1:0] wdata, // load byte
    input wire logic [$clog2(DEPTH)-1:0] raddr, // read address
    output logic [WIDTH-1:0] rdata // read byte, one cycle after raddr
);
    import prom_pkg::*;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rdata_d;

    always_comb begin
        rdata_d = FITTED ? mem[raddr] : {WIDTH{1'b1}};
    end

    always_ff @(posedge clk_sys) begin
        if (FITTED && we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata <= '1;
        end else begin
            rdata <= rdata_d;
        end
    end
endmodule

// ==== prom_pkg.sv ====
// constants shared by the data prom attachment and its controlling sequencer.
// assumes a single clk_sys domain at 250 MHz and a synchronous active-high reset.
// Overview of operation
// - each prom byte holds 256 eight-bit locations
// - first prom low byte, second prom high byte
// - absent prom byte reads as all ones
// - interface latches address, gates data onto bus
// - latched address holds until next address transfer
// - code 134 loads latch from register a
// - code 146 loads latch from register b
// - code 135 reads prom word into a
// - code 147 reads prom word into b
// - read path never inverts stored data
// - program complements a (011) or b (031)
// - both proms read at one latched address
// - latch must be loaded before any read
// - loader fills consecutive locations from zero
// - tape: octal byte, percent address, end marker
package prom_pkg;
    localparam int ADDR_W = 8;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int DEPTH = 256;
    localparam int CODE_W = 9;

    localparam logic [CODE_W-1:0] EVK_ADDR_FROM_A = 9'o134;
    localparam logic [CODE_W-1:0] EVK_ADDR_FROM_B = 9'o146;
    localparam logic [CODE_W-1:0] EVK_READ_TO_A = 9'o135;
    localparam logic [CODE_W-1:0] EVK_READ_TO_B = 9'o147;
    localparam logic [CODE_W-1:0] EVK_INVERT_A = 9'o011;
    localparam logic [CODE_W-1:0] EVK_INVERT_B = 9'o031;

    localparam real CLK_MHZ = 250.0;
    localparam real T_ADDR_US = 2.2;
    localparam real T_READ_US = 2.3;
    localparam real T_INVERT_US = 2.4;
    // products are whole numbers of cycles at this rate, so no rounding is lost
    localparam int ADDR_CYC = int'(T_ADDR_US * CLK_MHZ);
    localparam int READ_CYC = int'(T_READ_US * CLK_MHZ);
    localparam int INVERT_CYC = int'(T_INVERT_US * CLK_MHZ);
    localparam int CNT_W = 12;

    localparam logic [BYTE_W-1:0] ABSENT_BYTE = 8'hff;
    localparam logic [ADDR_W-1:0] LOAD_START = 8'h00;

    localparam logic [7:0] CH_PERCENT = 8'h25;
    localparam logic [7:0] CH_DOLLAR = 8'h24;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_SEVEN = 8'h37;

    typedef enum logic [2:0] {
        OP_SET_A,
        OP_SET_B,
        OP_ADDR_A,
        OP_ADDR_B,
        OP_READ_A,
        OP_READ_B,
        OP_INVERT_A,
        OP_INVERT_B
    } op_e;
endpackage

// ==== prom_sequencer.sv ====
// controlling sequencer end: registers a and b, evoke issue, complement, tape loader.
// assumes commands come from logic on clk_sys; tape characters one per strobe.
`timescale 1ns/10ps
module prom_sequencer (
    input wire logic clk_sys, // system clock
    input wire logic reset, // synchronous reset, active high
    rt_bus_if.sequencer bus, // register transfer bus
    input wire logic cmd_valid, // command request
    input wire prom_pkg::op_e cmd_op, // command kind
    input wire logic [prom_pkg::WORD_W-1:0] cmd_data, // value for set commands
    output logic cmd_ready, // idle, command accepted when valid
    output logic cmd_done, // pulse, command finished
    output logic cmd_error, // pulse, read refused before any address
    output logic [prom_pkg::WORD_W-1:0] reg_a, // register a
    output logic [prom_pkg::WORD_W-1:0] reg_b, // register b
    input wire logic tape_valid, // tape character strobe
    input wire logic [7:0] tape_char, // tape character
    input wire logic tape_sel, // 0 low prom, 1 high prom
    output logic tape_end // end marker seen
);
    import prom_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BUS,
        ST_INVERT
    } state_e;

    state_e state_q, state_d;
    op_e op_q, op_d;
    logic [WORD_W-1:0] a_q, a_d, b_q, b_d, src_q, src_d;
    logic [CODE_W-1:0] code_q, code_d;
    logic strobe_q, strobe_d, ready_q, ready_d, done_q, done_d, err_q, err_d;
    logic addressed_q, addressed_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    // tape loader state
    logic [ADDR_W-1:0] ptr_q, ptr_d, pa_q, pa_d;
    logic [BYTE_W:0] acc_q, acc_d;
    logic [1:0] ndig_q, ndig_d;
    logic pct_q, pct_d, cr_q, cr_d, end_q, end_d;
    logic we_q, we_d, sel_q, sel_d;
    logic [BYTE_W-1:0] pd_q, pd_d;
    logic is_digit;

    always_comb begin
        state_d = state_q;
        op_d = op_q;
        a_d = a_q;
        b_d = b_q;
        src_d = src_q;
        code_d = code_q;
        strobe_d = 1'b0;
        ready_d = ready_q;
        done_d = 1'b0;
        err_d = 1'b0;
        addressed_d = addressed_q;
        cnt_d = cnt_q;
        unique case (state_q)
            ST_IDLE: begin
                if (cmd_valid && ready_q) begin
                    op_d = cmd_op;
                    ready_d = 1'b0;
                    unique case (cmd_op)
                        OP_SET_A: begin
                            a_d = cmd_data;
                            done_d = 1'b1;
                            ready_d = 1'b1;
                        end
                        OP_SET_B: begin
                            b_d = cmd_data;
                            done_d = 1'b1;
                            ready_d = 1'b1;
                        end
                        OP_ADDR_A, OP_ADDR_B: begin
                            src_d = (cmd_op == OP_ADDR_A) ? a_q : b_q;
                            code_d = (cmd_op == OP_ADDR_A) ? EVK_ADDR_FROM_A
                                                           : EVK_ADDR_FROM_B;
                            strobe_d = 1'b1;
                            addressed_d = 1'b1;
                            state_d = ST_BUS;
                        end
                        OP_READ_A, OP_READ_B: begin
                            if (!addressed_q) begin
                                err_d = 1'b1;
                                done_d = 1'b1;
                                ready_d = 1'b1;
                            end else begin
                                code_d = (cmd_op == OP_READ_A) ? EVK_READ_TO_A
                                                               : EVK_READ_TO_B;
                                strobe_d = 1'b1;
                                state_d = ST_BUS;
                            end
                        end
                        OP_INVERT_A, OP_INVERT_B: begin
                            code_d = (cmd_op == OP_INVERT_A) ? EVK_INVERT_A : EVK_INVERT_B;
                            cnt_d = CNT_W'(INVERT_CYC - 1);
                            state_d = ST_INVERT;
                        end
                    endcase
                end
            end
            ST_BUS: begin
                if (bus.evoke_done) begin
                    if (op_q == OP_READ_A) a_d = bus.dst_data;
                    if (op_q == OP_READ_B) b_d = bus.dst_data;
                    done_d = 1'b1;
                    ready_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            ST_INVERT: begin
                if (cnt_q == '0) begin
                    // stored constants are complements, so this recovers the value
                    if (op_q == OP_INVERT_A) a_d = ~a_q;
                    if (op_q == OP_INVERT_B) b_d = ~b_q;
                    done_d = 1'b1;
                    ready_d = 1'b1;
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    assign is_digit = tape_char >= CH_ZERO && tape_char <= CH_SEVEN;

    // a byte entry is written only after its cr and lf; stray characters restart it
    always_comb begin
        ptr_d = ptr_q;
        pa_d = pa_q;
        acc_d = acc_q;
        ndig_d = ndig_q;
        pct_d = pct_q;
        cr_d = 1'b0;
        end_d = end_q;
        we_d = 1'b0;
        sel_d = sel_q;
        pd_d = pd_q;
        if (tape_valid && !end_q) begin
            if (is_digit && ndig_q != 2'd3) begin
                acc_d = {acc_q[BYTE_W-3:0], tape_char[2:0]};
                ndig_d = ndig_q + 2'd1;
                if (pct_q && ndig_q == 2'd2) begin
                    ptr_d = {acc_q[ADDR_W-4:0], tape_char[2:0]};
                    pct_d = 1'b0;
                    ndig_d = 2'd0;
                end
            end else if (tape_char == CH_CR && ndig_q == 2'd3 && !pct_q) begin
                cr_d = 1'b1;
            end else if (tape_char == CH_LF && cr_q) begin
                we_d = 1'b1;
                pa_d = ptr_q;
                pd_d = acc_q[BYTE_W-1:0];
                sel_d = tape_sel;
                ptr_d = ptr_q + 1'b1;
                ndig_d = 2'd0;
            end else if (tape_char == CH_PERCENT) begin
                pct_d = 1'b1;
                ndig_d = 2'd0;
            end else if (tape_char == CH_DOLLAR) begin
                end_d = 1'b1;
            end else begin
                ndig_d = 2'd0;
                pct_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= ST_IDLE;
            op_q <= OP_SET_A;
            a_q <= '0;
            b_q <= '0;
            src_q <= '0;
            code_q <= '0;
            strobe_q <= 1'b0;
            ready_q <= 1'b1;
            done_q <= 1'b0;
            err_q <= 1'b0;
            addressed_q <= 1'b0;
            cnt_q <= '0;
            ptr_q <= LOAD_START;
            pa_q <= '0;
            acc_q <= '0;
            ndig_q <= '0;
            pct_q <= 1'b0;
            cr_q <= 1'b0;
            end_q <= 1'b0;
            we_q <= 1'b0;
            sel_q <= 1'b0;
            pd_q <= '0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            a_q <= a_d;
            b_q <= b_d;
            src_q <= src_d;
            code_q <= code_d;
            strobe_q <= strobe_d;
            ready_q <= ready_d;
            done_q <= done_d;
            err_q <= err_d;
            addressed_q <= addressed_d;
            cnt_q <= cnt_d;
            ptr_q <= ptr_d;
            pa_q <= pa_d;
            acc_q <= acc_d;
            ndig_q <= ndig_d;
            pct_q <= pct_d;
            cr_q <= cr_d;
            end_q <= end_d;
            we_q <= we_d;
            sel_q <= sel_d;
            pd_q <= pd_d;
        end
    end

    assign bus.evoke_code = code_q;
    assign bus.evoke_strobe = strobe_q;
    assign bus.src_data = src_q;
    assign bus.prog_we = we_q;
    assign bus.prog_sel = sel_q;
    assign bus.prog_addr = pa_q;
    assign bus.prog_data = pd_q;
    assign cmd_ready = ready_q;
    assign cmd_done = done_q;
    assign cmd_error = err_q;
    assign reg_a = a_q;
    assign reg_b = b_q;
    assign tape_end = end_q;
endmodule

// ==== rt_bus_if.sv ====
// register transfer bus between the sequencer and the data prom attachment.
// assumes both ends run on the same clk_sys; the testbench joins them.
`timescale 1ns/10ps
interface rt_bus_if;
    logic [prom_pkg::CODE_W-1:0] evoke_code;
    logic evoke_strobe;
    logic [prom_pkg::WORD_W-1:0] src_data;
    logic [prom_pkg::WORD_W-1:0] dst_data;
    logic dst_drive;
    logic evoke_done;
    logic prog_we;
    logic prog_sel;
    logic [prom_pkg::ADDR_W-1:0] prog_addr;
    logic [prom_pkg::BYTE_W-1:0] prog_data;

    modport sequencer (
        output evoke_code, evoke_strobe, src_data, prog_we, prog_sel, prog_addr, prog_data,
        input dst_data, dst_drive, evoke_done
    );
    modport attachment (
        input evoke_code, evoke_strobe, src_data, prog_we, prog_sel, prog_addr, prog_data,
        output dst_data, dst_drive, evoke_done
    );
endinterface
